// ---- dp_i2c_target.sv ----
`timescale 1ns/1ps
`include "dp_defs.svh"

// How it works
// RULE1 - SDA fall with SCL high starts transaction
// RULE2 - SDA rise with SCL high stops transaction
// RULE3 - One bit per SCL pulse, eight per byte
// RULE4 - All bytes shift most significant bit first
// RULE5 - SDA changes only while SCL low
// RULE6 - Receiver acknowledges every byte
// RULE7 - Transmitter releases SDA; receiver pulls ninth clock low
// RULE8 - SDA high through ninth clock means not-acknowledge
// RULE9 - Target refuses bytes it cannot use
// RULE10 - Controller ends reads with not-acknowledge
// RULE11 - Pointer advances after every data byte
// RULE12 - Pointer wraps from access register to zero
// RULE13 - Repeated START accepted for reads
// RULE14 - Only controller drives the SCL clock
// RULE15 - Controller starts only on idle bus; the controller starts on cmd_valid without checking the bus lines
// RULE16 - Unlimited data bytes per transaction
// RULE17 - Write: address, data bytes, stop
// RULE18 - Read: address, target sends data, stop
// RULE19 - Bytes: device address, register address, data
// RULE20 - Address is 1010 plus three straps
// RULE21 - Acknowledge only own address, else stay silent
module dp_i2c_target (
	input wire logic link_clk,
	input wire logic sys_rst,
	dp_i2c_if.tgt bus,
	input wire logic addr_strap_hi,
	input wire logic addr_strap_mid,
	input wire logic addr_strap_lo,
	output logic [7:0] wiper_a_initial_value,
	output logic [7:0] wiper_b_initial_value,
	output logic [7:0] access_control,
	output logic busy
);

	// ------------------------------------------------------------------
	// Line sampling
	// ------------------------------------------------------------------
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic scl_f_reg;
	logic sda_f_reg;
	logic scl_q_reg;
	logic sda_q_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Three-stage synchronisers; a level counts once the last two stages agree.
	always_ff @(posedge link_clk) begin
		if (sys_rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_f_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_f_reg <= sda_sync_reg[2];
			end
			scl_q_reg <= scl_f_reg;
			sda_q_reg <= sda_f_reg;
		end
	end

	// Edge and condition detection on the filtered lines.
	assign scl_rise = scl_f_reg & ~scl_q_reg;
	assign scl_fall = ~scl_f_reg & scl_q_reg;
	assign start_det = scl_f_reg & scl_q_reg & sda_q_reg & ~sda_f_reg; // RULE1 RULE5
	assign stop_det = scl_f_reg & scl_q_reg & ~sda_q_reg & sda_f_reg; // RULE2 RULE5

	// ------------------------------------------------------------------
	// Address strap capture
	// ------------------------------------------------------------------
	logic [2:0] strap_reg;
	logic strap_done_reg;

	// Straps are caught once, in the first cycle after reset is released.
	always_ff @(posedge link_clk) begin
		if (sys_rst) begin
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_reg <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
			strap_done_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------------
	dp_pkg::dp_tgt_state_e state_reg;
	dp_pkg::dp_kind_e kind_reg;
	logic [7:0] shift_reg;
	logic [3:0] cnt_reg;
	logic [4:0] ptr_reg;
	logic rw_reg;
	logic ack_reg;
	logic sda_oe_reg;
	logic byte_done;
	logic addr_match;
	logic wr_en;
	logic [7:0] rd_data;
	logic [4:0] ptr_inc;
	logic [7:0] regs [0:`DP_REG_COUNT-1];

	assign byte_done = scl_fall && (cnt_reg == `DP_BITS_PER_BYTE); // RULE3
	assign addr_match = (shift_reg[7:1] == {`DP_DEV_ADDR_HI, strap_reg}); // RULE20
	assign wr_en = (state_reg == dp_pkg::DP_T_RX) && byte_done
		&& (kind_reg == dp_pkg::DP_K_DATA) && !rw_reg; // RULE17
	assign rd_data = regs[ptr_reg];
	assign ptr_inc = (ptr_reg == `DP_REG_LAST) ? `DP_REG_WIPER_A : ptr_reg + 5'h01; // RULE12

	// Byte sequencing, acknowledge and transmit shifting.
	always_ff @(posedge link_clk) begin
		if (sys_rst) begin
			state_reg <= dp_pkg::DP_T_IDLE;
			kind_reg <= dp_pkg::DP_K_DEV;
			shift_reg <= 8'h00;
			cnt_reg <= 4'h0;
			ptr_reg <= `DP_REG_WIPER_A;
			rw_reg <= `DP_RW_WRITE;
			ack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (start_det) begin
			// A repeated START restarts byte decoding but keeps the pointer.
			state_reg <= dp_pkg::DP_T_RX; // RULE1 RULE13
			kind_reg <= dp_pkg::DP_K_DEV; // RULE19
			cnt_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg <= dp_pkg::DP_T_IDLE; // RULE2
			sda_oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				dp_pkg::DP_T_RX: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_f_reg}; // RULE4
						cnt_reg <= cnt_reg + 4'h1; // RULE3
					end else if (byte_done) begin
						cnt_reg <= 4'h0;
						case (kind_reg) // RULE19
							dp_pkg::DP_K_DEV: begin
								if (addr_match) begin
									rw_reg <= shift_reg[0];
									kind_reg <= shift_reg[0] ? dp_pkg::DP_K_DATA
										: dp_pkg::DP_K_REG;
									ack_reg <= 1'b1;
									sda_oe_reg <= 1'b1; // RULE7
									state_reg <= dp_pkg::DP_T_ACK;
								end else begin
									state_reg <= dp_pkg::DP_T_IDLE; // RULE21
								end
							end
							dp_pkg::DP_K_REG: begin
								// Addresses beyond the map are refused.
								if (shift_reg <= {3'h0, `DP_REG_LAST}) begin
									ptr_reg <= shift_reg[4:0];
									kind_reg <= dp_pkg::DP_K_DATA;
									ack_reg <= 1'b1;
									sda_oe_reg <= 1'b1; // RULE6
								end else begin
									ack_reg <= 1'b0; // RULE9 RULE8
								end
								state_reg <= dp_pkg::DP_T_ACK;
							end
							default: begin
								ptr_reg <= ptr_inc; // RULE11 RULE16
								ack_reg <= 1'b1;
								sda_oe_reg <= 1'b1; // RULE6
								state_reg <= dp_pkg::DP_T_ACK;
							end
						endcase
					end
				end
				dp_pkg::DP_T_ACK: begin
					if (scl_fall) begin
						sda_oe_reg <= 1'b0; // RULE7
						if (!ack_reg) begin
							state_reg <= dp_pkg::DP_T_IDLE; // RULE9
						end else if (rw_reg) begin
							shift_reg <= rd_data; // RULE18
							sda_oe_reg <= ~rd_data[7]; // RULE4 RULE5
							cnt_reg <= 4'h1;
							ptr_reg <= ptr_inc; // RULE11
							state_reg <= dp_pkg::DP_T_TX;
						end else begin
							state_reg <= dp_pkg::DP_T_RX;
						end
					end
				end
				dp_pkg::DP_T_TX: begin
					if (byte_done) begin
						sda_oe_reg <= 1'b0; // RULE7
						state_reg <= dp_pkg::DP_T_TXACK;
					end else if (scl_fall) begin
						sda_oe_reg <= ~shift_reg[6]; // RULE4 RULE5
						shift_reg <= {shift_reg[6:0], 1'b0};
						cnt_reg <= cnt_reg + 4'h1; // RULE3
					end
				end
				dp_pkg::DP_T_TXACK: begin
					if (scl_rise) begin
						ack_reg <= ~sda_f_reg; // RULE8
					end else if (scl_fall) begin
						if (ack_reg) begin
							shift_reg <= rd_data;
							sda_oe_reg <= ~rd_data[7]; // RULE5
							cnt_reg <= 4'h1;
							ptr_reg <= ptr_inc; // RULE11 RULE12
							state_reg <= dp_pkg::DP_T_TX;
						end else begin
							state_reg <= dp_pkg::DP_T_IDLE; // RULE10
						end
					end
				end
				default: begin
					sda_oe_reg <= 1'b0; // RULE21
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	// One storage byte per address; the reserved address keeps its reset zero.
	genvar gi;
	generate
		for (gi = 0; gi < `DP_REG_COUNT; gi++) begin : g_reg
			localparam logic [4:0] IDX = 5'(gi);
			localparam logic [7:0] RST = (IDX == `DP_REG_WIPER_A || IDX == `DP_REG_WIPER_B)
				? `DP_RST_WIPER : (IDX == `DP_REG_ACCESS) ? `DP_RST_ACCESS : `DP_RST_GENERAL;
			always_ff @(posedge link_clk) begin
				if (sys_rst) begin
					regs[gi] <= RST;
				end else if (wr_en && ptr_reg == IDX && IDX != `DP_REG_RSVD) begin
					regs[gi] <= shift_reg; // RULE17
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// The target only ever pulls SDA low and never touches SCL.
	assign bus.tgt_sda_o = 1'b0; // RULE14
	assign bus.tgt_sda_oe = sda_oe_reg;
	assign wiper_a_initial_value = regs[`DP_REG_WIPER_A];
	assign wiper_b_initial_value = regs[`DP_REG_WIPER_B];
	assign access_control = regs[`DP_REG_ACCESS];
	assign busy = (state_reg != dp_pkg::DP_T_IDLE);

endmodule // dp_i2c_target

// ---- dp_defs.svh ----
`ifndef DP_DEFS_SVH
`define DP_DEFS_SVH

// ----------------------------------------------------------------------
// Bus address
// ----------------------------------------------------------------------
`define DP_DEV_ADDR_HI 4'hA
`define DP_RW_WRITE 1'h0
`define DP_RW_READ 1'h1

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DP_REG_COUNT 17
`define DP_REG_WIPER_A 5'h00
`define DP_REG_WIPER_B 5'h01
`define DP_REG_RSVD 5'h0F
`define DP_REG_ACCESS 5'h10
`define DP_REG_LAST 5'h10
`define DP_RST_WIPER 8'h80
`define DP_RST_ACCESS 8'h40
`define DP_RST_GENERAL 8'h00

// ----------------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------------
`define DP_BITS_PER_BYTE 4'h8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DP_CLK_SYS_NS 5
`define DP_SCL_PERIOD_NS 10000
`define DP_QTR_CYC ((`DP_SCL_PERIOD_NS / 4) / `DP_CLK_SYS_NS)

`endif

// ---- dp_pkg.sv ----
package dp_pkg;

	// ------------------------------------------------------------------
	// Target states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		DP_T_IDLE = 3'b000,
		DP_T_RX = 3'b001,
		DP_T_ACK = 3'b010,
		DP_T_TX = 3'b011,
		DP_T_TXACK = 3'b100
	} dp_tgt_state_e;

	// Position of the received byte within a transaction.
	typedef enum logic [1:0] {
		DP_K_DEV = 2'b00,
		DP_K_REG = 2'b01,
		DP_K_DATA = 2'b10
	} dp_kind_e;

	// ------------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		DP_C_IDLE = 2'b00,
		DP_C_START = 2'b01,
		DP_C_BIT = 2'b10,
		DP_C_STOP = 2'b11
	} dp_ctl_state_e;

	// Byte currently on the wire from the controller's view.
	typedef enum logic [2:0] {
		DP_B_DEVW = 3'b000,
		DP_B_REG = 3'b001,
		DP_B_DEVR = 3'b010,
		DP_B_DATW = 3'b011,
		DP_B_DATR = 3'b100
	} dp_byte_e;

endpackage

// ---- dp_i2c_if.sv ----
`timescale 1ns/1ps

interface dp_i2c_if;
	logic ctl_scl_o;
	logic ctl_scl_oe;
	logic ctl_sda_o;
	logic ctl_sda_oe;
	logic tgt_sda_o;
	logic tgt_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wired-AND with pull-ups: a line is low while any enabled driver pulls low.
	assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
	assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));

	modport ctl (
		output ctl_scl_o,
		output ctl_scl_oe,
		output ctl_sda_o,
		output ctl_sda_oe,
		input scl,
		input sda
	);

	modport tgt (
		output tgt_sda_o,
		output tgt_sda_oe,
		input scl,
		input sda
	);
endinterface

// ---- dp_i2c_controller.sv ----
`timescale 1ns/1ps
`include "dp_defs.svh"

module dp_i2c_controller #(
	parameter int QTR_CYC = `DP_QTR_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	dp_i2c_if.ctl bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [2:0] cmd_strap,
	input wire logic [7:0] cmd_reg,
	input wire logic [7:0] cmd_count,
	input wire logic [7:0] wdata,
	output logic wdata_take,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic done,
	output logic nack_err,
	output logic busy
);

	// ------------------------------------------------------------------
	// SDA sampling
	// ------------------------------------------------------------------
	logic [2:0] sda_sync_reg;
	logic sda_f_reg;

	// Three-stage synchroniser with agreement filter on the data line.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sda_sync_reg <= 3'h7;
			sda_f_reg <= 1'b1;
		end else begin
			sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_f_reg <= sda_sync_reg[2];
			end
		end
	end

	// ------------------------------------------------------------------
	// Quarter-period timebase
	// ------------------------------------------------------------------
	dp_pkg::dp_ctl_state_e state_reg;
	logic [15:0] qcnt_reg;
	logic [1:0] phase_reg;
	logic tick;

	assign tick = (state_reg != dp_pkg::DP_C_IDLE) && (qcnt_reg == 16'(QTR_CYC - 1));

	// Divider that paces SCL; four ticks make one SCL period.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state_reg == dp_pkg::DP_C_IDLE) begin
			qcnt_reg <= 16'h0000;
			phase_reg <= 2'h0;
		end else if (tick) begin
			qcnt_reg <= 16'h0000;
			phase_reg <= phase_reg + 2'h1;
		end else begin
			qcnt_reg <= qcnt_reg + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Transaction sequencer
	// ------------------------------------------------------------------
	dp_pkg::dp_byte_e bsel_reg;
	logic [8:0] out_reg;
	logic [7:0] in_reg;
	logic [3:0] bit_reg;
	logic [7:0] remain_reg;
	logic [2:0] strap_reg;
	logic [7:0] regaddr_reg;
	logic read_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	logic ack_in;

	// The acknowledge bit is the ninth sample, taken at the end of SCL high.
	assign ack_in = ~sda_f_reg;

	// Start, byte, repeated start and stop sequencing.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= dp_pkg::DP_C_IDLE;
			bsel_reg <= dp_pkg::DP_B_DEVW;
			out_reg <= 9'h1FF;
			in_reg <= 8'h00;
			bit_reg <= 4'h0;
			remain_reg <= 8'h00;
			strap_reg <= 3'h0;
			regaddr_reg <= 8'h00;
			read_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			rdata <= 8'h00;
			rdata_valid <= 1'b0;
			wdata_take <= 1'b0;
			done <= 1'b0;
			nack_err <= 1'b0;
		end else begin
			rdata_valid <= 1'b0;
			wdata_take <= 1'b0;
			done <= 1'b0;
			case (state_reg)
				dp_pkg::DP_C_IDLE: begin
					if (cmd_valid) begin
						read_reg <= cmd_read;
						strap_reg <= cmd_strap;
						regaddr_reg <= cmd_reg;
						remain_reg <= (cmd_read && cmd_count == 8'h00) ? 8'h01 : cmd_count;
						nack_err <= 1'b0;
						bsel_reg <= dp_pkg::DP_B_DEVW;
						out_reg <= {`DP_DEV_ADDR_HI, cmd_strap, `DP_RW_WRITE, 1'b1};
						state_reg <= dp_pkg::DP_C_START;
					end
				end
				dp_pkg::DP_C_START: begin
					// Works from idle and as a repeated start with SCL low.
					if (tick) begin
						case (phase_reg)
							2'h0: sda_oe_reg <= 1'b0;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b1;
							default: begin
								scl_oe_reg <= 1'b1;
								bit_reg <= 4'h0;
								state_reg <= dp_pkg::DP_C_BIT;
							end
						endcase
					end
				end
				dp_pkg::DP_C_BIT: begin
					if (tick) begin
						case (phase_reg)
							2'h0: sda_oe_reg <= ~out_reg[8];
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: scl_oe_reg <= 1'b0;
							default: begin
								scl_oe_reg <= 1'b1;
								in_reg <= {in_reg[6:0], sda_f_reg};
								out_reg <= {out_reg[7:0], 1'b1};
								bit_reg <= bit_reg + 4'h1;
								if (bit_reg == `DP_BITS_PER_BYTE) begin
									bit_reg <= 4'h0;
									case (bsel_reg)
										dp_pkg::DP_B_DEVW: begin
											bsel_reg <= dp_pkg::DP_B_REG;
											out_reg <= {regaddr_reg, 1'b1};
										end
										dp_pkg::DP_B_REG: begin
											if (read_reg) begin
												bsel_reg <= dp_pkg::DP_B_DEVR;
												out_reg <= {`DP_DEV_ADDR_HI, strap_reg, `DP_RW_READ, 1'b1};
												state_reg <= dp_pkg::DP_C_START;
											end else if (remain_reg == 8'h00) begin
												state_reg <= dp_pkg::DP_C_STOP;
											end else begin
												bsel_reg <= dp_pkg::DP_B_DATW;
												out_reg <= {wdata, 1'b1};
												wdata_take <= 1'b1;
											end
										end
										dp_pkg::DP_B_DEVR: begin
											bsel_reg <= dp_pkg::DP_B_DATR;
											out_reg <= {8'hFF, remain_reg == 8'h01}; // RULE10
										end
										dp_pkg::DP_B_DATW: begin
											remain_reg <= remain_reg - 8'h01;
											if (remain_reg == 8'h01) begin
												state_reg <= dp_pkg::DP_C_STOP;
											end else begin
												out_reg <= {wdata, 1'b1};
												wdata_take <= 1'b1;
											end
										end
										default: begin
											rdata <= in_reg;
											rdata_valid <= 1'b1;
											remain_reg <= remain_reg - 8'h01;
											if (remain_reg == 8'h01) begin
												state_reg <= dp_pkg::DP_C_STOP;
											end else begin
												out_reg <= {8'hFF, remain_reg == 8'h02}; // RULE10
											end
										end
									endcase
									// A refused byte written by us ends the transfer.
									if (bsel_reg != dp_pkg::DP_B_DATR && !ack_in) begin
										nack_err <= 1'b1;
										wdata_take <= 1'b0;
										state_reg <= dp_pkg::DP_C_STOP;
									end
								end
							end
						endcase
					end
				end
				default: begin
					if (tick) begin
						case (phase_reg)
							2'h0: sda_oe_reg <= 1'b1;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b0;
							default: begin
								done <= 1'b1;
								state_reg <= dp_pkg::DP_C_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign bus.ctl_scl_o = 1'b0;
	assign bus.ctl_sda_o = 1'b0;
	assign bus.ctl_scl_oe = scl_oe_reg; // RULE14
	assign bus.ctl_sda_oe = sda_oe_reg;
	assign cmd_ready = (state_reg == dp_pkg::DP_C_IDLE);
	assign busy = (state_reg != dp_pkg::DP_C_IDLE);

endmodule // dp_i2c_controller

// ---- dp_i2c_chk.sv ----
`timescale 1ns/1ps
`include "dp_defs.svh"

module dp_i2c_chk #(
	parameter int QTR_CYC = `DP_QTR_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ctl_scl_o,
	input wire logic ctl_scl_oe,
	input wire logic ctl_sda_o,
	input wire logic ctl_sda_oe,
	input wire logic tgt_sda_o,
	input wire logic tgt_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------------------
	// Phase counters
	// ------------------------------------------------------------
	logic [31:0] hi_cnt;
	logic [31:0] lo_cnt;

	// Counts how long the clock line has stayed high.
	always_ff @(posedge clk_sys) begin
		hi_cnt <= (sys_rst || !scl) ? 32'h0 : hi_cnt + 32'h1;
	end

	// Counts how long the clock line has stayed low.
	always_ff @(posedge clk_sys) begin
		lo_cnt <= (sys_rst || scl) ? 32'h0 : lo_cnt + 32'h1;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_ctl_scl_low: assert property (ctl_scl_o == 1'b0)
		else $error("controller drives the clock line high");
	a_tgt_sda_low: assert property (tgt_sda_o == 1'b0)
		else $error("target drives data line high");
	a_tgt_sda_change: assert property ($changed(tgt_sda_oe) |-> !scl)
		else $error("target changed data while clock high");
	a_one_sda_driver: assert property (scl && $past(scl) |-> !(tgt_sda_oe && ctl_sda_oe))
		else $error("both parties pull data during clock high");
	a_start_scl_fall: assert property ($fell(sda) && scl && $past(scl) |-> ##[1:1000] !scl)
		else $error("no clock pulse after start");
	a_stop_bus_idle: assert property ($rose(sda) && scl && $past(scl) |-> (scl && !tgt_sda_oe)[*8])
		else $error("bus not idle after stop");
	a_scl_high_min: assert property ($fell(scl) |-> hi_cnt >= 32'(QTR_CYC))
		else $error("clock high phase too short");
	a_scl_low_min: assert property ($rose(scl) |-> lo_cnt >= 32'(QTR_CYC))
		else $error("clock low phase too short");

	// Main scenarios: start, target acknowledge, stop.
	c_start: cover property ($fell(sda) && scl && $past(scl));
	c_tgt_ack: cover property (tgt_sda_oe && scl);
	c_stop: cover property ($rose(sda) && scl && $past(scl));
endmodule // dp_i2c_chk

// ---- i2c_target_register_access_test.sv ----
`timescale 1ns/1ps
`include "dp_defs.svh"

module i2c_target_register_access_test;
	localparam int QTR = 60;
	localparam logic [2:0] STRAP = 3'h5;
	logic clk_sys = 1'b0;
	logic link_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] strap_pins = STRAP;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [2:0] cmd_strap = STRAP;
	logic [7:0] cmd_reg = 8'h00;
	logic [7:0] cmd_count = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic cmd_ready, wdata_take, rdata_valid, done, nack_err;
	logic [7:0] rdata, wiper_a, wiper_b, acc;
	logic tgt_busy;
	logic [7:0] wbuf [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] rbuf [4];
	int fails = 0;
	int checks = 0;

	// ------------------------------------------------------------
	// Clocks, bus and units
	// ------------------------------------------------------------
	// The link clock is kept out of phase with the system clock.
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end

	dp_i2c_if bus_if();

	dp_i2c_controller #(.QTR_CYC(QTR)) u_dp_i2c_controller (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .bus(bus_if.ctl), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_read(cmd_read), .cmd_strap(cmd_strap), .cmd_reg(cmd_reg), .cmd_count(cmd_count),
		.wdata(wdata), .wdata_take(wdata_take), .rdata(rdata), .rdata_valid(rdata_valid),
		.done(done), .nack_err(nack_err), .busy());

	dp_i2c_target u_dp_i2c_target (.link_clk(link_clk), .sys_rst(sys_rst), .bus(bus_if.tgt),
		.addr_strap_hi(strap_pins[2]), .addr_strap_mid(strap_pins[1]),
		.addr_strap_lo(strap_pins[0]), .wiper_a_initial_value(wiper_a),
		.wiper_b_initial_value(wiper_b), .access_control(acc), .busy(tgt_busy));

	dp_i2c_chk #(.QTR_CYC(QTR)) u_dp_i2c_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.ctl_scl_o(bus_if.ctl_scl_o), .ctl_scl_oe(bus_if.ctl_scl_oe),
		.ctl_sda_o(bus_if.ctl_sda_o), .ctl_sda_oe(bus_if.ctl_sda_oe),
		.tgt_sda_o(bus_if.tgt_sda_o), .tgt_sda_oe(bus_if.tgt_sda_oe),
		.scl(bus_if.scl), .sda(bus_if.sda));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Compares one byte and counts the outcome.
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Runs one command, feeding write bytes and collecting read bytes.
	task automatic xfer(input logic rd, input logic [2:0] strap, input logic [7:0] addr,
		input logic [7:0] n);
		int wi;
		int ri;
		int k;
		wi = 0;
		ri = 0;
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_strap = strap;
		cmd_reg = addr;
		cmd_count = n;
		wdata = wbuf[0];
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// Outputs are looked at mid-cycle, where they have settled.
		for (k = 0; k < 30000; k++) begin
			@(negedge clk_sys);
			if (rdata_valid === 1'b1 && ri < 4) begin
				rbuf[ri] = rdata;
				ri++;
			end
			if (wdata_take === 1'b1 && wi < 3) wi++;
			if (done === 1'b1) break;
			wdata = wbuf[wi];
		end
		chk8({7'h00, done}, 8'h01);
		chk8({7'h00, cmd_ready}, 8'h01);
		chk8({7'h00, tgt_busy}, 8'h00);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		#480000;
		fails++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge link_clk);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (6) @(posedge link_clk);
		chk8(wiper_a, `DP_RST_WIPER);
		chk8(wiper_b, `DP_RST_WIPER);
		chk8(acc, `DP_RST_ACCESS);
		// Reset values read back over the bus with a repeated start.
		xfer(1'b1, STRAP, 8'h00, 8'h02);
		chk8(rbuf[0], `DP_RST_WIPER);
		chk8(rbuf[1], `DP_RST_WIPER);
		// Two bytes written from one address phase.
		wbuf = '{8'hA5, 8'h3C, 8'h00, 8'h00};
		xfer(1'b0, STRAP, 8'h00, 8'h02);
		chk8(wiper_a, 8'hA5);
		chk8(wiper_b, 8'h3C);
		chk8({7'h00, nack_err}, 8'h00);
		// Writing past the access register wraps to the first wiper.
		wbuf = '{8'h5A, 8'hC3, 8'h00, 8'h00};
		xfer(1'b0, STRAP, 8'h10, 8'h02);
		chk8(acc, 8'h5A);
		chk8(wiper_a, 8'hC3);
		// Reading across the wrap, last byte refused by the controller.
		xfer(1'b1, STRAP, 8'h10, 8'h03);
		chk8(rbuf[0], 8'h5A);
		chk8(rbuf[1], 8'hC3);
		chk8(rbuf[2], 8'h3C);
		// Three bytes through the reserved place into the access register.
		wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
		xfer(1'b0, STRAP, 8'h0E, 8'h03);
		chk8(acc, 8'h33);
		xfer(1'b1, STRAP, 8'h0E, 8'h02);
		chk8(rbuf[0], 8'h11);
		chk8(rbuf[1], 8'h00);
		// An address-only write moves nothing; a zero-count read gives one byte.
		xfer(1'b0, STRAP, 8'h01, 8'h00);
		chk8(wiper_b, 8'h3C);
		chk8({7'h00, nack_err}, 8'h00);
		xfer(1'b1, STRAP, 8'h01, 8'h00);
		chk8(rbuf[0], 8'h3C);
		// Another strap value is not answered and changes nothing.
		wbuf = '{8'hFF, 8'h00, 8'h00, 8'h00};
		xfer(1'b0, STRAP ^ 3'h1, 8'h00, 8'h01);
		chk8({7'h00, nack_err}, 8'h01);
		chk8(wiper_a, 8'hC3);
		// A register address beyond the map is refused.
		xfer(1'b0, STRAP, 8'h11, 8'h01);
		chk8({7'h00, nack_err}, 8'h01);
		chk8(acc, 8'h33);
		report_and_stop();
	end
endmodule // i2c_target_register_access_test
